// ### hw/xli_pkg.sv
// Package with constants and types for the X.21 switched line interface
package xli_pkg;
  // ==========================================================
  // Register map (APB byte addresses)
  localparam logic [7:0] XLI_CTRL_ADDR = 8'h00;
  localparam logic [7:0] XLI_TXD_ADDR = 8'h04;
  localparam logic [7:0] XLI_STAT_ADDR = 8'h08;
  localparam logic [7:0] XLI_IRQ_STAT_ADDR = 8'h0c;
  localparam logic [7:0] XLI_IRQ_EN_ADDR = 8'h10;
  localparam logic [7:0] XLI_IRQ_CLR_ADDR = 8'h14;
  // ==========================================================
  // Control field positions
  localparam int XLI_C_DIAG = 0;
  localparam int XLI_C_DTR = 1;
  localparam int XLI_C_CALLSEL = 2;
  localparam int XLI_C_SEND = 3;
  localparam int XLI_C_XMIT = 4;
  localparam int XLI_C_EXTCLK = 5;
  localparam int XLI_C_SCANMON = 6;
  localparam int XLI_CTRL_W = 7;
  // Status field positions
  localparam int XLI_S_BITREQ = 0;
  localparam int XLI_S_OVERRUN = 1;
  localparam int XLI_S_RXBUF = 2;
  localparam int XLI_S_CHANGE = 3;
  localparam int XLI_S_DCERDY = 4;
  localparam int XLI_S_TXBUF = 5;
  // Interrupt bit positions
  localparam int XLI_I_BITREQ = 0;
  localparam int XLI_I_OVERRUN = 1;
  localparam int XLI_I_MODEMCHK = 2;
  localparam int XLI_IRQ_W = 3;
  // ==========================================================
  // Fixed patterns
  localparam logic [3:0] XLI_T_ZEROS = 4'h0;
  localparam logic [3:0] XLI_T_ALT = 4'h5;
  localparam logic [3:0] XLI_T_ONES = 4'hf;
  localparam logic [15:0] XLI_NR_PATTERN = 16'h7f68;
  localparam logic [3:0] XLI_NR_LAST = 4'hf;
  localparam logic [1:0] XLI_ALT_LAST = 2'h3;
  // Interrupt level carried with modem check
  localparam logic [1:0] XLI_MODEMCHK_LEVEL = 2'h2;
  typedef enum logic [2:0] {
    XLI_ST_CTL_NR = 3'b000,
    XLI_ST_UNC_NR = 3'b001,
    XLI_ST_READY = 3'b010,
    XLI_ST_CALLREQ = 3'b011,
    XLI_ST_DATA = 3'b100
  } xli_state_t;
endpackage

// ### hw/xli_sync_if.sv
// Interface carrying a synchronised strobe and its falling edge
interface xli_sync_if;
  logic level;
  logic fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface

// ### hw/xli_edge_sync.sv
// Two-flop synchroniser with falling edge detector
module xli_edge_sync (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic async_in, // Input from another domain
  xli_sync_if.src sync // Synchronised level and fall pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  // ==========================================================
  // Only sync_reg reads the first stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end
  assign sync.level = sync_reg;
  assign sync.fall = last_reg & ~sync_reg;
endmodule

// ### hw/xli_top.sv
// X.21 switched line interface top with APB registers
module xli_top
  import xli_pkg::*;
(
  input wire logic sys_clk, // 250 MHz clock
  input wire logic sys_rst, // Synchronous reset, high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic internal_bit_clock_pulse, // Bit clock strobe, same domain
  input wire logic osc_clk, // Selected oscillator pin
  input wire logic dce_clk, // Network signal element timing pin
  input wire logic dce_rx_data, // Receive circuit R pin
  input wire logic dce_ready, // Indication of DCE ready pin
  output logic x21_control, // Control circuit C
  output logic x21_transmit, // Transmit circuit T
  output logic [1:0] irq_level, // Level carried with modem check
  output logic irq // Level interrupt
);
  // ==========================================================
  // Synchronisers for pins
  xli_sync_if dce_clk_s ();
  xli_sync_if osc_s ();
  xli_sync_if rxd_s ();
  xli_sync_if rdy_s ();
  xli_edge_sync u_sync_dce (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(dce_clk), .sync(dce_clk_s));
  xli_edge_sync u_sync_osc (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(osc_clk), .sync(osc_s));
  xli_edge_sync u_sync_rxd (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(dce_rx_data), .sync(rxd_s));
  xli_edge_sync u_sync_rdy (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .async_in(dce_ready), .sync(rdy_s));

  // ==========================================================
  // Registers
  logic [XLI_CTRL_W-1:0] ctrl_reg;
  logic send_data_reg;
  logic tx_buf_reg;
  logic rx_buf_reg;
  logic bit_req_reg;
  logic overrun_reg;
  logic [XLI_IRQ_W-1:0] irq_stat_reg;
  logic [XLI_IRQ_W-1:0] irq_en_reg;
  logic [3:0] nr_idx_reg;
  logic [1:0] t_idx_reg;
  logic [31:0] prdata_reg;

  // Latch views
  wire diag_latch = ctrl_reg[XLI_C_DIAG];
  wire dtr_latch = ctrl_reg[XLI_C_DTR];
  wire call_select_latch = ctrl_reg[XLI_C_CALLSEL];
  wire send_request_latch = ctrl_reg[XLI_C_SEND];
  wire xmit_latch = ctrl_reg[XLI_C_XMIT];
  wire ext_clk_latch = ctrl_reg[XLI_C_EXTCLK];
  wire scan_monitor = ctrl_reg[XLI_C_SCANMON];

  // ==========================================================
  // APB decode; zero wait states, every address answered
  wire apb_access = psel & penable;
  wire apb_wr = apb_access & pwrite;
  wire apb_rd = apb_access & ~pwrite;
  wire wr_ctrl = apb_wr & (paddr == XLI_CTRL_ADDR);
  wire wr_txd = apb_wr & (paddr == XLI_TXD_ADDR);
  wire wr_en = apb_wr & (paddr == XLI_IRQ_EN_ADDR);
  wire wr_clr = apb_wr & (paddr == XLI_IRQ_CLR_ADDR);
  wire rd_stat = apb_rd & (paddr == XLI_STAT_ADDR);
  wire addr_ok = (paddr == XLI_CTRL_ADDR) | (paddr == XLI_TXD_ADDR) |
                 (paddr == XLI_STAT_ADDR) | (paddr == XLI_IRQ_STAT_ADDR) |
                 (paddr == XLI_IRQ_EN_ADDR) | (paddr == XLI_IRQ_CLR_ADDR);
  assign pready = 1'b1;
  assign pslverr = apb_access & ~addr_ok;

  // ==========================================================
  // Strobe source choice
  wire strobe_fall = xmit_latch ? (ext_clk_latch ? dce_clk_s.fall : osc_s.fall) :
                     ext_clk_latch ? dce_clk_s.fall : internal_bit_clock_pulse;

  // ==========================================================
  // Interface state from the latches
  xli_state_t state;
  assign state = diag_latch ? XLI_ST_UNC_NR :
                 !dtr_latch && !send_request_latch ? XLI_ST_CTL_NR :
                 dtr_latch && !send_request_latch ? XLI_ST_READY :
                 dtr_latch && call_select_latch ? XLI_ST_CALLREQ :
                 dtr_latch ? XLI_ST_DATA : XLI_ST_CTL_NR;

  // Fixed T patterns step one bit per strobe
  wire alt_bit = XLI_T_ALT[t_idx_reg];
  logic t_next;
  logic c_next;
  always_comb begin
    t_next = 1'b0;
    c_next = 1'b0;
    unique case (state)
      XLI_ST_UNC_NR: t_next = XLI_T_ZEROS[t_idx_reg];
      XLI_ST_CTL_NR: t_next = alt_bit;
      XLI_ST_READY: t_next = XLI_T_ONES[t_idx_reg];
      XLI_ST_CALLREQ: begin
        c_next = 1'b1;
        t_next = XLI_T_ZEROS[t_idx_reg];
      end
      XLI_ST_DATA: begin
        c_next = 1'b1;
        t_next = tx_buf_reg;
      end
    endcase
  end

  // ==========================================================
  // Receive path
  wire nr_bit = XLI_NR_PATTERN[4'(XLI_NR_LAST - nr_idx_reg)];
  wire test_data = tx_buf_reg; // Wrap of transmit data
  wire line_bit = rdy_s.level ? rxd_s.level : nr_bit;
  wire rx_bit = diag_latch ? test_data : line_bit;
  wire line_change = rx_bit ^ rx_buf_reg;
  // Monitor state seeing the fixed pattern means DCE not ready
  wire modem_check = scan_monitor & ~rdy_s.level & strobe_fall;

  // ==========================================================
  // Strobe driven data path
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_buf_reg <= 1'b0;
      rx_buf_reg <= 1'b0;
      nr_idx_reg <= 4'h0;
      t_idx_reg <= 2'h0;
    end else if (strobe_fall) begin
      tx_buf_reg <= send_data_reg;
      rx_buf_reg <= rx_bit;
      nr_idx_reg <= rdy_s.level ? 4'h0 : 4'(nr_idx_reg + 4'h1);
      t_idx_reg <= (t_idx_reg == XLI_ALT_LAST) ? 2'h0 : 2'(t_idx_reg + 2'h1);
    end
  end

  // Line outputs registered
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      x21_control <= 1'b0;
      x21_transmit <= 1'b0;
    end else begin
      x21_control <= c_next;
      x21_transmit <= t_next;
    end
  end

  // ==========================================================
  // Bit service handshake; set wins over clear
  wire bitreq_clr = wr_clr & pwdata[XLI_I_BITREQ];
  wire ovr_clr = wr_clr & pwdata[XLI_I_OVERRUN];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bit_req_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      bit_req_reg <= strobe_fall | (bit_req_reg & ~bitreq_clr);
      overrun_reg <= (strobe_fall & bit_req_reg & ~bitreq_clr) |
                     (overrun_reg & ~ovr_clr);
    end
  end

  // ==========================================================
  // Software latches
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg <= '0;
      send_data_reg <= 1'b0;
      irq_en_reg <= '0;
    end else begin
      if (wr_ctrl) ctrl_reg <= pwdata[XLI_CTRL_W-1:0];
      if (wr_txd) send_data_reg <= pwdata[0];
      if (wr_en) irq_en_reg <= pwdata[XLI_IRQ_W-1:0];
    end
  end

  // Sticky interrupt status, set beats clear
  // Overrun event matches the flag: a clear in the strobe cycle counts as served
  wire ovr_event = strobe_fall & bit_req_reg & ~bitreq_clr;
  wire [XLI_IRQ_W-1:0] irq_set = {modem_check, ovr_event, strobe_fall};
  wire [XLI_IRQ_W-1:0] irq_clr_mask = wr_clr ? pwdata[XLI_IRQ_W-1:0] : '0;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr_mask);
    end
  end
  assign irq = |(irq_stat_reg & irq_en_reg);
  assign irq_level = irq_stat_reg[XLI_I_MODEMCHK] ? XLI_MODEMCHK_LEVEL : 2'h0;

  // ==========================================================
  // Read mux, registered in setup cycle for the access phase
  wire [31:0] stat_word = {26'h0, tx_buf_reg, rdy_s.level, line_change,
                           rx_buf_reg, overrun_reg, bit_req_reg};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      XLI_CTRL_ADDR: rd_mux = {25'h0, ctrl_reg};
      XLI_TXD_ADDR: rd_mux = {31'h0, send_data_reg};
      XLI_STAT_ADDR: rd_mux = stat_word;
      XLI_IRQ_STAT_ADDR: rd_mux = {29'h0, irq_stat_reg};
      XLI_IRQ_EN_ADDR: rd_mux = {29'h0, irq_en_reg};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) prdata_reg <= 32'h0;
    else if (psel & ~penable) prdata_reg <= rd_mux;
  end
  assign prdata = prdata_reg;
endmodule

// ### verification/xli_top_assertions.sv
// Port checker for the X.21 line interface
module xli_top_assertions
  import xli_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic internal_bit_clock_pulse, // Strobe
  input wire logic x21_control, // Circuit C
  input wire logic x21_transmit, // Circuit T
  input wire logic [1:0] irq_level, // Level
  input wire logic irq // Interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Latch shadow from bus writes; strobe only counts in receive mode with internal clocking
  logic [6:0] ctl_reg;
  logic txd_reg;
  wire wr = psel && penable && pwrite;
  wire stb = internal_bit_clock_pulse && !ctl_reg[4] && !ctl_reg[5];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl_reg <= 7'h0;
      txd_reg <= 1'b0;
    end else if (wr && paddr == XLI_CTRL_ADDR) begin
      ctl_reg <= pwdata[6:0];
    end else if (wr && paddr == XLI_TXD_ADDR) begin
      txd_reg <= pwdata[0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Circuits settle two edges after a strobe
  chk_diag_zero: assert property (stb && ctl_reg[0] |-> ##2 (!x21_control && !x21_transmit))
    else $error("diag state wrong");
  chk_off_control: assert property (stb && ctl_reg[1:0] == 2'h0 |-> ##2 !x21_control)
    else $error("not ready control wrong");
  chk_ready_ones: assert property (
    stb && ctl_reg[3:0] ==? 4'b0x10 |-> ##2 (!x21_control && x21_transmit))
    else $error("ready state wrong");
  chk_call_request: assert property (
    stb && ctl_reg[3:0] == 4'he |-> ##2 (x21_control && !x21_transmit))
    else $error("call request wrong");
  chk_send_data: assert property (
    stb && ctl_reg[3:0] == 4'ha |-> ##2 (x21_control && x21_transmit == $past(txd_reg, 2)))
    else $error("data state wrong");
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("ready missing");
  chk_unmapped_err: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("error missing");
  chk_mapped_ok: assert property (psel && penable && paddr[1:0] == 2'h0 && paddr <= 8'h14 |-> !pslverr)
    else $error("spurious error");
  chk_mask_off: assert property (wr && paddr == XLI_IRQ_EN_ADDR && pwdata[2:0] == 3'h0 |=> !irq)
    else $error("masked interrupt high");
  chk_clear_all: assert property (
    wr && paddr == XLI_IRQ_CLR_ADDR && pwdata[2:0] == 3'h7 && !internal_bit_clock_pulse
    && !ctl_reg[4] && !ctl_reg[5] |=> (!irq && irq_level == 2'h0))
    else $error("clear failed");
  cov_data_state: cover property (stb && ctl_reg[3:0] == 4'ha);
  cov_modem_check: cover property (irq_level == 2'h2);
  cov_refused: cover property (psel && penable && pslverr);
endmodule
bind xli_top xli_top_assertions xli_top_assertions_inst (.sys_clk, .sys_rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .internal_bit_clock_pulse, .x21_control,
  .x21_transmit, .irq_level, .irq);

// ### verification/xli_dce_model.sv
// Far-side model: element timing, receive circuit, ready indication
module xli_dce_model (
  input wire logic run, // Send frame
  input wire logic rdy, // Ready level
  input wire logic line, // Level between frames
  input wire logic [15:0] bits, // Frame, msb first
  output logic dce_clk, // Element timing
  output logic dce_rx_data, // Receive circuit
  output logic dce_ready // Ready indication
);
  timeunit 1ns;
  timeprecision 100ps;
  int idx;
  assign dce_ready = rdy;
  // ==========================================
  // Timing runs only within frames; data moves on the rise, stable at the fall
  initial begin
    dce_clk = 1'b1;
    dce_rx_data = 1'b0;
    idx = 0;
    #1.3;
    forever begin
      if (run) begin
        dce_rx_data = bits[15 - idx];
        idx = (idx + 1) % 16;
        #80 dce_clk = 1'b0;
        #80 dce_clk = 1'b1;
      end else begin
        #10 dce_rx_data = line;
        idx = 0;
      end
    end
  end
endmodule

// ### verification/xli_top_bench.sv
// Self-checking bench for the X.21 line interface
module xli_top_bench
  import xli_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, sys_rst, psel, penable, pwrite, pulse, osc_clk, run, rdy, line;
  logic pready, pslverr, erq, t0, x21_control, x21_transmit, irq, dce_clk, dce_rx, dce_ready;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] irq_level;
  logic [15:0] bits;
  int miscompares, n_checks;
  localparam logic [3:0] st_ctl [6] = '{4'h1, 4'hf, 4'h2, 4'he, 4'ha, 4'ha};
  localparam logic st_txd [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  localparam logic [1:0] st_ct [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
  localparam logic [15:0] nr_pat = 16'h7f68;
  xli_top xli_top_inst (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .internal_bit_clock_pulse(pulse), .osc_clk, .dce_clk,
    .dce_rx_data(dce_rx), .dce_ready, .x21_control, .x21_transmit, .irq_level, .irq);
  xli_dce_model xli_dce_model_inst (.run, .rdy, .line, .bits, .dce_clk,
    .dce_rx_data(dce_rx), .dce_ready);
  // ==========================================
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Setup, then access held until ready; idle gap keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    q = prdata;
    erq = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic strobe();
    pulse <= 1'b1;
    @(posedge sys_clk);
    pulse <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #40000;
    miscompares++;
    wrap_up();
  end
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, pulse, osc_clk, run, line} = 7'h0;
    {paddr, pwdata} = 40'h0;
    rdy = 1'b1;
    bits = 16'hc000;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values and a refused address
    rdc(XLI_CTRL_ADDR, 32'hffffffff, 32'h0);
    rdc(XLI_STAT_ADDR, 32'hffffffff, 32'h10);
    rdc(XLI_IRQ_EN_ADDR, 32'hffffffff, 32'h0);
    rdc(8'h40, 32'hffffffff, 32'h0);
    chk({31'h0, erq}, 32'h1);
    // Bit request, overrun, masking and clearing
    apb(1'b1, XLI_IRQ_EN_ADDR, 32'h7);
    strobe();
    rdc(XLI_STAT_ADDR, 32'h3, 32'h1);
    chk({31'h0, irq}, 32'h1);
    strobe();
    rdc(XLI_IRQ_STAT_ADDR, 32'h3, 32'h3);
    apb(1'b1, XLI_IRQ_EN_ADDR, 32'h0);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, XLI_IRQ_CLR_ADDR, 32'h7);
    rdc(XLI_IRQ_STAT_ADDR, 32'h7, 32'h0);
    strobe();
    rdc(XLI_STAT_ADDR, 32'h3, 32'h1);
    // Latch combinations; fixed states ignore send data
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, XLI_CTRL_ADDR, {28'h0, st_ctl[i]});
      apb(1'b1, XLI_TXD_ADDR, {31'h0, st_txd[i]});
      strobe();
      strobe();
      chk({30'h0, x21_control, x21_transmit}, {30'h0, st_ct[i]});
    end
    apb(1'b1, XLI_CTRL_ADDR, 32'h8);
    strobe();
    t0 = x21_transmit;
    strobe();
    chk({30'h0, x21_control, x21_transmit ^ t0}, 32'h1);
    // Capture and line change with diag off
    apb(1'b1, XLI_CTRL_ADDR, 32'h2);
    line <= 1'b1;
    repeat (10) @(posedge sys_clk);
    strobe();
    rdc(XLI_STAT_ADDR, 32'hc, 32'h4);
    line <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rdc(XLI_STAT_ADDR, 32'hc, 32'hc);
    strobe();
    rdc(XLI_STAT_ADDR, 32'hc, 32'h0);
    // Diag wraps send data while the line stays low
    apb(1'b1, XLI_CTRL_ADDR, 32'h1);
    apb(1'b1, XLI_TXD_ADDR, 32'h1);
    strobe();
    strobe();
    rdc(XLI_STAT_ADDR, 32'h2c, 32'h24);
    // Fill pattern and modem check while far side not ready
    apb(1'b1, XLI_CTRL_ADDR, 32'h40);
    apb(1'b1, XLI_IRQ_EN_ADDR, 32'h4);
    rdy <= 1'b0;
    repeat (10) @(posedge sys_clk);
    for (int i = 15; i >= 0; i--) begin
      strobe();
      rdc(XLI_STAT_ADDR, 32'h4, {29'h0, nr_pat[i], 2'h0});
    end
    chk({29'h0, irq_level, irq}, 32'h5);
    apb(1'b1, XLI_CTRL_ADDR, 32'h0);
    apb(1'b1, XLI_IRQ_CLR_ADDR, 32'h7);
    strobe();
    rdc(XLI_IRQ_STAT_ADDR, 32'h4, 32'h0);
    rdy <= 1'b1;
    // Oscillator strobes in transmit mode; bit clock ignored there
    apb(1'b1, XLI_CTRL_ADDR, 32'h10);
    apb(1'b1, XLI_IRQ_CLR_ADDR, 32'h3);
    strobe();
    rdc(XLI_STAT_ADDR, 32'h1, 32'h0);
    osc_clk <= 1'b1;
    repeat (8) @(posedge sys_clk);
    osc_clk <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rdc(XLI_STAT_ADDR, 32'h1, 32'h1);
    // Network timing with external clocking captures frame bits
    apb(1'b1, XLI_CTRL_ADDR, 32'h20);
    apb(1'b1, XLI_IRQ_CLR_ADDR, 32'h3);
    run <= 1'b1;
    repeat (60) @(posedge sys_clk);
    run <= 1'b0;
    repeat (100) @(posedge sys_clk);
    rdc(XLI_STAT_ADDR, 32'h5, 32'h5);
    wrap_up();
  end
endmodule
